// ===== dv/nvl_flash_model.sv
// Purpose: flash read port model
// Assumes: reads fall in FFAE..FFBF
// Notes: bench fills mem; idle data toggles
`timescale 1ns/1ps
`default_nettype none
module nvl_flash_model (
  // ctl
  input wire logic i_clk,
  input wire logic i_slow,
  // read
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_data,
  output logic o_valid
);
  logic [7:0] mem [0:17];
  logic [1:0] cnt_q = 2'h0;
  initial o_data = 8'h00;
  initial o_valid = 1'b0;
  // one read outstanding; answer after 1 or 3 cycles
  always @(posedge i_clk) begin
    o_valid <= cnt_q == 2'h1;
    o_data <= (cnt_q == 2'h1) ? mem[5'(i_addr - 16'hFFAE)] : ~o_data;
    if (i_rd) begin
      cnt_q <= i_slow ? 2'h3 : 2'h1;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule // nvl_flash_model
`default_nettype wire

// ===== dv/nvl_loader_props.sv
// Purpose: port checker for nvl_loader
// Assumes: single clock domain
// Notes: trim timing left to the bench
`timescale 1ns/1ps
`default_nettype none
module nvl_loader_props
  import nvl_pkg::*;
(
  // clk
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_bdm_at_reset,
  // flash
  input wire logic [15:0] o_flash_addr_q,
  input wire logic [7:0] i_flash_data,
  input wire logic i_flash_valid,
  // regs
  input wire logic [7:0] o_protection_working_reg_q,
  input wire logic [7:0] o_option_working_reg_q,
  input wire logic [7:0] o_clock_coarse_trim_reg_q,
  input wire logic o_fine_trim_bit_q,
  input wire logic o_load_done_q,
  // key
  input wire logic i_key_check,
  input wire logic i_exec_secure,
  input wire logic i_bdm_access,
  input wire logic i_blank_check_ok,
  input wire logic o_secure_q,
  input wire logic o_key_match_q,
  input wire logic o_key_reject_q
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_opt_taken;
    o_flash_addr_q == NVL_ADDR_OPT && i_flash_valid && !o_load_done_q;
  endsequence
  sequence s_answer;
    o_key_match_q != o_key_reject_q;
  endsequence
  a_prot_copy: assert property (o_flash_addr_q == NVL_ADDR_PROT && i_flash_valid && !o_load_done_q
    |=> o_protection_working_reg_q == $past(i_flash_data)) else $error("prot byte not copied");
  a_opt_decode: assert property (s_opt_taken |=> o_option_working_reg_q == $past(i_flash_data)
    ##1 o_secure_q == (o_option_working_reg_q[NVL_OPT_SEC_HI:NVL_OPT_SEC_LO] != NVL_SEC_UNSECURED))
    else $error("opt decode wrong");
  a_dbg_trim: assert property ($rose(o_load_done_q) && i_bdm_at_reset |->
    o_clock_coarse_trim_reg_q == NVL_BDM_COARSE_TRIM && o_fine_trim_bit_q == NVL_BDM_FINE_TRIM)
    else $error("debug trim wrong");
  a_key_gate: assert property (i_key_check && (!o_load_done_q || !o_option_working_reg_q[NVL_OPT_KEY_ENABLE_BIT_BIT]
    || !i_exec_secure || i_bdm_access) |=> !o_key_match_q) else $error("gated key matched");
  a_key_answer: assert property (i_key_check |=> s_answer) else $error("no key answer");
  a_match_unsec: assert property (o_key_match_q |-> !o_secure_q) else $error("match kept secure");
  a_blank_unlock: assert property (i_blank_check_ok && o_load_done_q |=> !o_secure_q)
    else $error("blank check kept secure");
  a_reset_secure: assert property (disable iff (1'b0) !i_rst_b |=> o_secure_q)
    else $error("reset left unsecured");
  a_unsec_hold: assert property (!o_secure_q |=> !o_secure_q) else $error("unsecure lost");
endmodule // nvl_loader_props
bind nvl_loader nvl_loader_props chk_u (.*);
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench for nvl_loader
// Assumes: flash model answers after 1 or 3 cycles
// Notes: expected state kept in bench variables
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvl_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, background_debug_state = 1'b0, slow = 1'b0, cwr = 1'b0, fwr = 1'b0, fdat = 1'b0;
  logic kwr = 1'b0, kchk = 1'b0, exs = 1'b0, dba = 1'b0, blank = 1'b0, sec_m;
  logic [7:0] cdat = 8'h00, kdat = 8'h00, opt_m;
  logic [2:0] kidx = 3'h0;
  logic rd, valid, fine, done, secq, mq, rq;
  logic [15:0] addr;
  logic [7:0] fdata, prot, opt, coarse;
  logic [63:0] key_m, pres_m;
  int fail_count = 0;
  int n_checks = 0;
  nvl_flash_model flash_u (.i_clk(clk), .i_slow(slow), .i_rd(rd), .i_addr(addr), .o_data(fdata), .o_valid(valid));
  nvl_loader dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_bdm_at_reset(background_debug_state), .o_flash_rd_q(rd),
    .o_flash_addr_q(addr), .i_flash_data(fdata), .i_flash_valid(valid), .o_protection_working_reg_q(prot),
    .o_option_working_reg_q(opt), .o_clock_coarse_trim_reg_q(coarse), .o_fine_trim_bit_q(fine),
    .o_load_done_q(done), .i_coarse_trim_wr(cwr), .i_coarse_trim_data(cdat), .i_fine_trim_wr(fwr),
    .i_fine_trim_data(fdat), .i_key_byte_wr(kwr), .i_key_byte_idx(kidx), .i_key_byte_data(kdat),
    .i_key_check(kchk), .i_exec_secure(exs), .i_bdm_access(dba), .i_blank_check_ok(blank),
    .o_secure_q(secq), .o_key_match_q(mq), .o_key_reject_q(rq));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic boot(input logic b, input logic s, input logic [7:0] o);
    int i;
    for (i = 0; i < 18; i++) flash_u.mem[i] = 8'($urandom);
    flash_u.mem[17] = o;
    for (i = 0; i < 8; i++) key_m[8*i +: 8] = flash_u.mem[2 + i];
    opt_m = o;
    pres_m = 64'h0;
    background_debug_state = b;
    slow = s;
    rst_b = 1'b0;
    tick(6);
    chk(secq, 1'b1, "secure in reset");
    rst_b = 1'b1;
    for (i = 0; i < 300 && done !== 1'b1; i++) tick(1);
    sec_m = o[1:0] != NVL_SEC_UNSECURED;
    chk(done, 1'b1, "load done");
    chk(prot, flash_u.mem[15], "prot copy");
    chk(opt, o, "opt copy");
    chk(coarse, b ? 8'h80 : flash_u.mem[1], "coarse trim");
    chk(fine, b ? 1'b0 : flash_u.mem[0][0], "fine trim");
    chk(secq, sec_m, "security decode");
  endtask
  task automatic key_try(input logic [63:0] k, input logic s, input logic d);
    int i;
    logic e;
    exs = s;
    dba = d;
    for (i = 0; i < 8; i++) begin
      kwr = 1'b1;
      kidx = 3'(i);
      kdat = k[8*i +: 8];
      tick(1);
    end
    kwr = 1'b0;
    kchk = 1'b1;
    if (s && !d) pres_m = k;
    e = opt_m[7] && s && !d && pres_m === key_m;
    sec_m = sec_m && !e;
    tick(1);
    kchk = 1'b0;
    chk(mq, e, "key match");
    chk(rq, !e, "key reject");
    chk(secq, sec_m, "key security");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    int t;
    void'($urandom(57807));
    for (t = 0; t < 4; t++) begin
      boot(t[0], t[1], {1'($urandom), 5'($urandom), 2'(t)});
      $display("boot test %0d done", t);
    end
    boot(1'b0, 1'b0, 8'h83);
    cdat = 8'($urandom);
    fdat = 1'($urandom);
    cwr = 1'b1;
    fwr = 1'b1;
    tick(1);
    cwr = 1'b0;
    fwr = 1'b0;
    chk(coarse, cdat, "user coarse trim");
    chk(fine, fdat, "user fine trim");
    key_try(key_m, 1'b1, 1'b1);
    key_try(key_m, 1'b0, 1'b0);
    key_try(key_m ^ 64'h1, 1'b1, 1'b0);
    key_try(key_m, 1'b1, 1'b0);
    key_try(key_m, 1'b1, 1'b0);
    $display("trim and key test done");
    boot(1'b0, 1'b0, 8'h83);
    boot(1'b1, 1'b1, 8'h03);
    key_try(key_m, 1'b1, 1'b0);
    blank = 1'b1;
    tick(1);
    blank = 1'b0;
    sec_m = 1'b0;
    chk(secq, sec_m, "blank check unlock");
    $display("disabled key test done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire

// ===== hw/nvl_key_cmp.sv
// Purpose: byte-wise comparison of a presented key against the stored key
// Assumes: both keys are stable while the result is sampled
// Notes: purely combinational; the caller registers the verdict
`timescale 1ns/1ps
`default_nettype none
module nvl_key_cmp #(
  parameter int BYTES = 8
) (
  // keys
  input wire logic [8*BYTES-1:0] i_stored,
  input wire logic [8*BYTES-1:0] i_presented,
  // verdict
  output logic o_match
);
  logic [BYTES-1:0] byte_eq;

  generate
    for (genvar g = 0; g < BYTES; g++) begin : g_byte
      assign byte_eq[g] = (i_stored[8*g +: 8] == i_presented[8*g +: 8]);
    end
  endgenerate

  assign o_match = &byte_eq;
endmodule // nvl_key_cmp
`default_nettype wire

// ===== hw/nvl_loader.sv
// Purpose: reset-time copy of protection, option, trim and key bytes; security state and backdoor key
// Assumes: flash answers each read strobe with i_flash_valid one or more cycles later
// Notes: user code may overwrite the trims once o_load_done_q is high
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - copy protection and option bytes at reset
// RULE_02 - outside debug, load factory trims into clock
// RULE_03 - in debug reset, load fixed default trim
// RULE_04 - user code may copy trims in itself
// RULE_05 - key enable lets key match unsecure
// RULE_06 - key only from secure code, never debug
// RULE_07 - key disabled: only erase plus blank check
// RULE_08 - security field 1:0 means unsecured
// RULE_09 - key unsecure lasts until next reset
module nvl_loader
  import nvl_pkg::*;
#(
  parameter int KEY_BYTES = NVL_KEY_BYTES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // debug state sampled at reset release
  input wire logic i_bdm_at_reset,
  // flash read port
  output logic o_flash_rd_q,
  output logic [15:0] o_flash_addr_q,
  input wire logic [7:0] i_flash_data,
  input wire logic i_flash_valid,
  // working registers
  output logic [7:0] o_protection_working_reg_q,
  output logic [7:0] o_option_working_reg_q,
  output logic [7:0] o_clock_coarse_trim_reg_q,
  output logic o_fine_trim_bit_q,
  output logic o_load_done_q,
  // user trim override
  input wire logic i_coarse_trim_wr,
  input wire logic [7:0] i_coarse_trim_data,
  input wire logic i_fine_trim_wr,
  input wire logic i_fine_trim_data,
  // backdoor key entry
  input wire logic i_key_byte_wr,
  input wire logic [2:0] i_key_byte_idx,
  input wire logic [7:0] i_key_byte_data,
  input wire logic i_key_check,
  input wire logic i_exec_secure,
  input wire logic i_bdm_access,
  // mass erase result
  input wire logic i_blank_check_ok,
  // security state
  output logic o_secure_q,
  output logic o_key_match_q,
  output logic o_key_reject_q
);
  // the load sequence and its last index are laid out for exactly this many key bytes
  generate
    if (KEY_BYTES != NVL_KEY_BYTES) begin : g_key_len_check
      $error("nvl_loader: key length must be %0d bytes", NVL_KEY_BYTES);
    end
  endgenerate

  nvl_state_t state_q;
  nvl_state_t state_d;
  logic [3:0] idx_q;
  logic bdm_q;
  logic [8*KEY_BYTES-1:0] key_stored_q;
  logic [8*KEY_BYTES-1:0] key_presented_q;
  logic key_match;
  logic take;
  logic key_ok;

  function automatic logic [15:0] nvl_addr_of(input logic [3:0] idx);
    case (idx)
      NVL_IDX_PROT: nvl_addr_of = NVL_ADDR_PROT;
      NVL_IDX_OPT: nvl_addr_of = NVL_ADDR_OPT;
      NVL_IDX_FINE: nvl_addr_of = NVL_ADDR_FINE_TRIM;
      NVL_IDX_COARSE: nvl_addr_of = NVL_ADDR_COARSE_TRIM;
      default: nvl_addr_of = NVL_ADDR_KEY_BASE + {12'h000, idx - NVL_IDX_KEY0};
    endcase
  endfunction

  // a byte is taken when the flash answers during the load
  assign take = (state_q == NVL_ST_WAIT) && i_flash_valid;

  always_comb begin
    state_d = state_q;
    case (state_q)
      NVL_ST_CAPTURE: state_d = NVL_ST_REQ;
      NVL_ST_REQ: state_d = NVL_ST_WAIT;
      NVL_ST_WAIT: begin
        if (i_flash_valid) begin
          state_d = (idx_q == NVL_IDX_LAST) ? NVL_ST_DONE : NVL_ST_REQ;
        end
      end
      NVL_ST_DONE: state_d = NVL_ST_DONE;
      default: state_d = NVL_ST_CAPTURE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= NVL_ST_CAPTURE;
    end else begin
      state_q <= state_d;
    end
  end

  // strap is caught by a clocked process after release, never by the reset itself
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bdm_q <= 1'b0;
    end else if (state_q == NVL_ST_CAPTURE) begin
      bdm_q <= i_bdm_at_reset;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      idx_q <= NVL_IDX_PROT;
      o_flash_rd_q <= 1'b0;
      o_flash_addr_q <= NVL_RST_ADDR;
    end else begin
      o_flash_rd_q <= (state_q == NVL_ST_REQ);
      if (state_q == NVL_ST_REQ) begin
        o_flash_addr_q <= nvl_addr_of(idx_q);
      end
      if (take) begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_protection_working_reg_q <= NVL_RST_BYTE;
      o_option_working_reg_q <= NVL_RST_BYTE;
    end else if (take) begin
      if (idx_q == NVL_IDX_PROT) begin
        o_protection_working_reg_q <= i_flash_data; // RULE_01
      end
      if (idx_q == NVL_IDX_OPT) begin
        o_option_working_reg_q <= i_flash_data; // RULE_01
      end
    end
  end

  // trims: flash copy outside debug, fixed default in debug, user override after load
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_clock_coarse_trim_reg_q <= NVL_RST_BYTE;
      o_fine_trim_bit_q <= 1'b0;
    end else if (state_q == NVL_ST_DONE) begin
      if (i_coarse_trim_wr) begin
        o_clock_coarse_trim_reg_q <= i_coarse_trim_data; // RULE_04
      end
      if (i_fine_trim_wr) begin
        o_fine_trim_bit_q <= i_fine_trim_data; // RULE_04
      end
    end else if (take && idx_q == NVL_IDX_FINE) begin
      o_fine_trim_bit_q <= bdm_q ? NVL_BDM_FINE_TRIM : i_flash_data[NVL_FINE_TRIM_BIT]; // RULE_02 RULE_03
    end else if (take && idx_q == NVL_IDX_COARSE) begin
      o_clock_coarse_trim_reg_q <= bdm_q ? NVL_BDM_COARSE_TRIM : i_flash_data; // RULE_02 RULE_03
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      key_stored_q <= NVL_RST_KEY;
    end else if (take && idx_q >= NVL_IDX_KEY0) begin
      key_stored_q[8*(idx_q - NVL_IDX_KEY0) +: 8] <= i_flash_data;
    end
  end

  // writes from debug commands never reach the presented key
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      key_presented_q <= NVL_RST_KEY;
    end else if (i_key_byte_wr && i_exec_secure && !i_bdm_access) begin
      key_presented_q[8*i_key_byte_idx +: 8] <= i_key_byte_data; // RULE_06
    end
  end

  nvl_key_cmp #(
    .BYTES(KEY_BYTES)
  ) u_cmp (
    .i_stored(key_stored_q),
    .i_presented(key_presented_q),
    .o_match(key_match)
  );

  assign key_ok = (state_q == NVL_ST_DONE) && o_option_working_reg_q[NVL_OPT_KEY_ENABLE_BIT_BIT]
    && i_exec_secure && !i_bdm_access; // RULE_05 RULE_06 RULE_07

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_key_match_q <= 1'b0;
      o_key_reject_q <= 1'b0;
    end else begin
      o_key_match_q <= i_key_check && key_ok && key_match; // RULE_05
      o_key_reject_q <= i_key_check && !(key_ok && key_match); // RULE_06 RULE_07
    end
  end

  // secure from reset until the option byte decides; an unlock holds only until reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_secure_q <= 1'b1; // RULE_09
    end else if (take && idx_q == NVL_IDX_OPT) begin
      o_secure_q <= (i_flash_data[NVL_OPT_SEC_HI:NVL_OPT_SEC_LO] != NVL_SEC_UNSECURED); // RULE_08
    end else if (state_q == NVL_ST_DONE && (i_blank_check_ok || (i_key_check && key_ok && key_match))) begin
      o_secure_q <= 1'b0; // RULE_05 RULE_07
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_load_done_q <= 1'b0;
    end else begin
      o_load_done_q <= (state_d == NVL_ST_DONE);
    end
  end
endmodule // nvl_loader
`default_nettype wire

// ===== hw/nvl_pkg.sv
// Purpose: shared constants for the nonvolatile configuration and security loader
// Assumes: byte-wide flash read port, 16-bit flash addresses
// Notes: the loader's flash locations, field positions and multi-bit reset values live here
package nvl_pkg;
  // nonvolatile locations in flash
  localparam logic [15:0] NVL_ADDR_FINE_TRIM = 16'hFFAE;
  localparam logic [15:0] NVL_ADDR_COARSE_TRIM = 16'hFFAF;
  localparam logic [15:0] NVL_ADDR_KEY_BASE = 16'hFFB0;
  localparam logic [15:0] NVL_ADDR_PROT = 16'hFFBD;
  localparam logic [15:0] NVL_ADDR_OPT = 16'hFFBF;

  // fields of the option byte
  localparam int NVL_OPT_KEY_ENABLE_BIT_BIT = 7;
  localparam int NVL_OPT_SEC_HI = 1;
  localparam int NVL_OPT_SEC_LO = 0;
  localparam logic [1:0] NVL_SEC_UNSECURED = 2'h2;
  // fine trim sits in bit 0 of its location
  localparam int NVL_FINE_TRIM_BIT = 0;

  // trim loaded when reset enters background debug
  localparam logic [7:0] NVL_BDM_COARSE_TRIM = 8'h80;
  localparam logic NVL_BDM_FINE_TRIM = 1'b0;

  // load sequence: protection, option, fine trim, coarse trim, then key bytes
  localparam int NVL_KEY_BYTES = 8;
  localparam logic [3:0] NVL_IDX_PROT = 4'h0;
  localparam logic [3:0] NVL_IDX_OPT = 4'h1;
  localparam logic [3:0] NVL_IDX_FINE = 4'h2;
  localparam logic [3:0] NVL_IDX_COARSE = 4'h3;
  localparam logic [3:0] NVL_IDX_KEY0 = 4'h4;
  localparam logic [3:0] NVL_IDX_LAST = 4'hB;

  // values after reset
  localparam logic [7:0] NVL_RST_BYTE = 8'h00;
  localparam logic [15:0] NVL_RST_ADDR = 16'h0000;
  localparam logic [63:0] NVL_RST_KEY = 64'h0000_0000_0000_0000;

  typedef enum logic [3:0] {
    NVL_ST_CAPTURE = 4'h1,
    NVL_ST_REQ = 4'h2,
    NVL_ST_WAIT = 4'h4,
    NVL_ST_DONE = 4'h8
  } nvl_state_t;
endpackage : nvl_pkg
